// *** spi_frame_status_map.svh ***
// offsets, field positions and reset values of the serial frame interface
`ifndef SPI_FRAME_STATUS_MAP_SVH
`define SPI_FRAME_STATUS_MAP_SVH

// frame geometry
`define FRAME_BITS     6'd32
`define CMD_LAST_BIT   6'd7
`define CNT_MAX        6'h3F

// addressable register space
`define ADDR_CR1       6'h01
`define ADDR_CR4       6'h04
`define ADDR_SR1       6'h05
`define ADDR_SR3       6'h07
`define ADDR_CLR_ALL   6'h3F

// information area
`define ROM_FRAME_FMT  6'h10
`define ROM_STAT_OPT   6'h3E
`define FRAME_FMT_VAL  8'h31
`define STAT_OPT_VAL   8'h00

// control register reset values
`define CR1_RST        24'h802000
`define CR2_RST        24'h0200F0
`define CR3_RST        24'h00CD80
`define CR4_RST        24'h000000
`define UNLOCK_POS     1

// status byte bit positions
`define STAT_NOSTAT    7
`define STAT_RESET     6
`define STAT_SERR      5
`define STAT_NONCRIT   4
`define STAT_CRIT      3
`define STAT_CHIP      2
`define STAT_WARN      1
`define STAT_LIMP      0

`endif

// *** spi_frame_status_pkg.sv ***
// types shared by the serial frame interface
`default_nettype none
package spi_frame_status_pkg;

	typedef enum logic [1:0] {
		OP_WRITE     = 2'h0,
		OP_READ      = 2'h1,
		OP_READ_CLR  = 2'h2,
		OP_READ_INFO = 2'h3
	} opcode_type;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h1,
		ST_FRAME = 2'h2
	} state_type;

	typedef struct packed {
		logic longOnTimeFlag;
		logic shortOnTimeFlag;
		logic longOffTimeFlag;
		logic shortOffTimeFlag;
		logic openLoadFlag;
		logic overtempFlag;
		logic shortCircuitFlag;
		logic tempWarningLow;
		logic tempWarningHigh;
	} chan_fault_type;

	typedef struct packed {
		logic supplyUndervoltageFlag;
		logic boostFeedbackFailure;
		logic dimmingClockFailure;
		logic powerNotGood;
		logic boostOvervoltage;
	} chip_fault_type;

	typedef struct packed {
		chan_fault_type ch1;
		chan_fault_type ch2;
		chip_fault_type chip;
	} fault_type;

	typedef struct packed {
		logic [23:0] cr1;
		logic [23:0] cr2;
		logic [23:0] cr3;
		logic [23:0] cr4;
	} ctrl_type;

endpackage
`default_nettype wire

// *** spi_frame_status_interface.sv ***
// serial command and status frame interface of the led driver
//
// Behaviour
// - each frame is 32 bits: command byte then three data bytes.
// - command bits 31:30 opcode, 29:24 address; write, read, read-clear, info.
// - write reaches control registers, read reaches control and status registers by address.
// - read-clear returns the status register, then clears it.
// - info read returns a value from the separate read-only area.
// - status byte shifts out first, then three response bytes.
// - write frame returns the register value from before the write.
// - info address 10h holds the 8-bit frame format value.
// - status bit 31 is the nor of bits 30 to 24.
// - reset flag set after reset, holds control defaults, clears on valid frame.
// - serial error flag ors stuck input, wrong clock count, parity failure on a write.
// - noncritical fault flag ors off-time and long on-time faults.
// - critical fault flag ors the disabling faults of both channels, supply undervoltage and boost feedback failure.
// - chip fault flag ors dimming clock, power not good, boost overvoltage.
// - warning flag ors the four temperature warnings.
// - limp-home flag follows the fail-safe mode.
// - frame bit 0 is odd parity, checked by the device on write frames only.
// - unlock bit clears itself on the next valid frame.
// - read-clear to address 3Fh clears every status register.
`timescale 1ns/10ps
`default_nettype none
`include "spi_frame_status_map.svh"

module spi_frame_status_interface #(
	parameter logic [7:0] FRAME_FORMAT = `FRAME_FMT_VAL
) (
	// clock, reset, enable
	input  wire logic                            core_clk,
	input  wire logic                            rst_n,
	input  wire logic                            clkEn,
	// serial link pins
	input  wire logic                            sclk,
	input  wire logic                            csN,
	input  wire logic                            sdi,
	output var  logic                            sdo,
	output var  logic                            sdoOe,
	// fault and mode inputs from the driver core
	input  wire spi_frame_status_pkg::fault_type faultIn,
	input  wire logic                            limpHome,
	// control registers and serial error flag towards the driver core
	output var  spi_frame_status_pkg::ctrl_type  ctrlOut,
	output var  logic                            serialErr
);
	import spi_frame_status_pkg::*;

	function automatic logic isCtrl(input logic [5:0] a);
		return (a >= `ADDR_CR1) && (a <= `ADDR_CR4);
	endfunction

	function automatic logic isStat(input logic [5:0] a);
		return (a >= `ADDR_SR1) && (a <= `ADDR_SR3);
	endfunction

	function automatic logic [23:0] ctrlDefault(input logic [1:0] i);
		logic [23:0] v;
		unique case (i)
			2'h0: v = `CR1_RST;
			2'h1: v = `CR2_RST;
			2'h2: v = `CR3_RST;
			2'h3: v = `CR4_RST;
		endcase
		return v;
	endfunction

	// synchronisers: stage 0 is read only by stage 1
	logic [2:0]  sclkS;
	logic [2:0]  csS;
	logic [1:0]  sdiS;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkS <= 3'h0;
			csS   <= 3'h7;
			sdiS  <= 2'h0;
		end else if (clkEn) begin
			sclkS <= {sclkS[1:0], sclk};
			csS   <= {csS[1:0], csN};
			sdiS  <= {sdiS[0], sdi};
		end
	end

	wire         sclkRise = sclkS[1] & ~sclkS[2];
	wire         sclkFall = ~sclkS[1] & sclkS[2];
	wire         csFall   = ~csS[1] & csS[2];
	wire         csRise   = csS[1] & ~csS[2];
	wire         sdiBit   = sdiS[1];

	// frame state
	state_type   stateQ;
	logic [31:0] rxQ;
	logic [31:0] txQ;
	logic [5:0]  cntQ;
	logic        sdoQ;
	logic        rstFlagQ;
	logic        serialErrQ;
	logic [23:0] crQ [4];
	logic [23:0] srQ [3];

	wire         inFrame = (stateQ == ST_FRAME);

	// command byte completes on the eighth rising edge
	wire         cmdDone  = inFrame && sclkRise && (cntQ == `CMD_LAST_BIT);
	wire [7:0]   cmdNow   = {rxQ[6:0], sdiBit};
	wire [1:0]   cmdOp    = cmdNow[7:6];
	wire [5:0]   cmdAddr  = cmdNow[5:0];
	wire [1:0]   cmdCrIdx = 2'(cmdAddr - `ADDR_CR1);
	wire [1:0]   cmdSrIdx = 2'(cmdAddr - `ADDR_SR1);

	// information area is apart from the register space; unlisted addresses read zero
	function automatic logic [23:0] infoWord(input logic [5:0] a);
		logic [23:0] v;
		v = 24'h000000;
		if (a == `ROM_FRAME_FMT)
			v = {16'h0000, FRAME_FORMAT};
		else if (a == `ROM_STAT_OPT)
			v = {16'h0000, `STAT_OPT_VAL};
		return v;
	endfunction

	wire [23:0]  romWord  = infoWord(cmdAddr);

	// snapshot taken before any write of this frame lands
	wire [23:0]  ramWord  =
		isCtrl(cmdAddr) ? crQ[cmdCrIdx] :
		isStat(cmdAddr) ? srQ[cmdSrIdx] :
		24'h000000;

	wire [23:0]  respWord =
		(opcode_type'(cmdOp) == OP_READ_INFO) ? romWord : ramWord;

	// frame end decode
	wire         endFrame = inFrame && csRise;
	wire [1:0]   endOp    = rxQ[31:30];
	wire [5:0]   endAddr  = rxQ[29:24];
	wire [23:0]  endData  = rxQ[23:0];
	wire [1:0]   endCrIdx = 2'(endAddr - `ADDR_CR1);
	wire [1:0]   endSrIdx = 2'(endAddr - `ADDR_SR1);
	wire         isWrite  = (opcode_type'(endOp) == OP_WRITE);
	wire         isRdClr  = (opcode_type'(endOp) == OP_READ_CLR);

	// a frame is acted on only when every serial check passes
	wire         countOk   = (cntQ == `FRAME_BITS);
	wire         stuckLow  = (rxQ == 32'h00000000);
	wire         stuckHigh = (rxQ == 32'hFFFFFFFF);
	wire         stuck     = stuckLow | stuckHigh;
	// parity only guards writes; a bad read costs nothing
	wire         parityOk  = ^rxQ;
	wire         parityBad = isWrite & ~parityOk;
	wire         frameOk   = countOk & ~stuck & ~parityBad;

	wire         goodEnd  = endFrame & frameOk;
	wire         badEnd   = endFrame & ~frameOk;

	// writes are blocked while the reset flag holds defaults
	wire         doWrite  = goodEnd & isWrite & isCtrl(endAddr) & ~rstFlagQ;
	wire         clrAll   = goodEnd & isRdClr & (endAddr == `ADDR_CLR_ALL);
	wire         clrOne   = goodEnd & isRdClr & isStat(endAddr);

	// sticky status captured from the core every cycle
	wire [23:0]  srSet [3];
	assign srSet[0] = {15'h0000, faultIn.ch1};
	assign srSet[1] = {15'h0000, faultIn.ch2};
	assign srSet[2] = {19'h00000, faultIn.chip};

	chan_fault_type st1;
	chan_fault_type st2;
	chip_fault_type stc;
	assign st1 = chan_fault_type'(srQ[0][8:0]);
	assign st2 = chan_fault_type'(srQ[1][8:0]);
	assign stc = chip_fault_type'(srQ[2][4:0]);

	// global status byte, one named wire per flag
	wire noncriticalFaultFlag =
		st1.longOffTimeFlag |
		st2.longOffTimeFlag |
		st1.shortOffTimeFlag |
		st2.shortOffTimeFlag |
		st1.longOnTimeFlag |
		st2.longOnTimeFlag;
	wire criticalFaultFlag =
		stc.supplyUndervoltageFlag |
		st1.openLoadFlag |
		st2.openLoadFlag |
		st1.overtempFlag |
		st2.overtempFlag |
		st1.shortCircuitFlag |
		st2.shortCircuitFlag |
		st1.shortOnTimeFlag |
		st2.shortOnTimeFlag |
		stc.boostFeedbackFailure;
	wire chipFaultFlag =
		stc.dimmingClockFailure |
		stc.powerNotGood |
		stc.boostOvervoltage;
	wire globalWarningFlag =
		st1.tempWarningLow |
		st1.tempWarningHigh |
		st2.tempWarningLow |
		st2.tempWarningHigh;
	wire resetOccurredFlag = rstFlagQ;
	wire serialErrorFlag   = serialErrQ;
	// limp-home is live: the byte shows the mode at select fall
	wire limpHomeFlag      = limpHome;
	wire noStatusSetFlag   = ~(resetOccurredFlag |
		serialErrorFlag |
		noncriticalFaultFlag |
		criticalFaultFlag |
		chipFaultFlag |
		globalWarningFlag |
		limpHomeFlag);

	logic [7:0] statusByte;
	always_comb begin
		statusByte                = 8'h00;
		statusByte[`STAT_RESET]   = resetOccurredFlag;
		statusByte[`STAT_SERR]    = serialErrorFlag;
		statusByte[`STAT_NONCRIT] = noncriticalFaultFlag;
		statusByte[`STAT_CRIT]    = criticalFaultFlag;
		statusByte[`STAT_CHIP]    = chipFaultFlag;
		statusByte[`STAT_WARN]    = globalWarningFlag;
		statusByte[`STAT_LIMP]    = limpHomeFlag;
		statusByte[`STAT_NOSTAT]  = noStatusSetFlag;
	end

	// next output bit after a rising edge count of cntQ
	wire [4:0]   txIdx   = 5'(6'd31 - cntQ);
	wire         txBit   = (cntQ < `FRAME_BITS) ? txQ[txIdx] : 1'b0;

	// frame sequencing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= ST_IDLE;
		end else if (clkEn) begin
			unique case (stateQ)
				ST_IDLE:  if (csFall) stateQ <= ST_FRAME;
				ST_FRAME: if (csRise) stateQ <= ST_IDLE;
			endcase
		end
	end

	// receive shifter and clock counter, saturating so overruns show
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxQ  <= 32'h00000000;
			cntQ <= 6'h00;
		end else if (clkEn) begin
			if (csFall) begin
				rxQ  <= 32'h00000000;
				cntQ <= 6'h00;
			end else if (inFrame && sclkRise) begin
				rxQ  <= {rxQ[30:0], sdiBit};
				if (cntQ != `CNT_MAX)
					cntQ <= cntQ + 6'h01;
			end
		end
	end

	// transmit side: status byte ready before the first clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txQ  <= 32'h00000000;
			sdoQ <= 1'b0;
		end else if (clkEn) begin
			if (csFall) begin
				txQ  <= {statusByte, 24'h000000};
				sdoQ <= statusByte[7];
			end else if (cmdDone) begin
				txQ[23:0] <= respWord;
			end else if (inFrame && sclkFall) begin
				sdoQ <= txBit;
			end
		end
	end

	// output enable follows the synchronised select
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			sdoOe <= 1'b0;
		else if (clkEn)
			sdoOe <= inFrame & ~csRise;
	end

	assign sdo = sdoQ;

	// flags: reset flag sticks until a clean frame
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstFlagQ   <= 1'b1;
			serialErrQ <= 1'b0;
		end else if (clkEn) begin
			if (goodEnd)
				rstFlagQ <= 1'b0;
			if (badEnd)
				serialErrQ <= 1'b1;
			else if (goodEnd)
				serialErrQ <= 1'b0;
		end
	end

	assign serialErr = serialErrQ;

	// control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++)
				crQ[i] <= ctrlDefault(2'(i));
		end else if (clkEn) begin
			for (int i = 0; i < 4; i++) begin
				if (rstFlagQ)
					crQ[i] <= ctrlDefault(2'(i));
				else if (doWrite && endCrIdx == 2'(i))
					crQ[i] <= endData;
			end
			// unlock only lives for one frame
			if (goodEnd && !rstFlagQ && !(doWrite && endCrIdx == 2'h0))
				crQ[0][`UNLOCK_POS] <= 1'b0;
		end
	end

	assign ctrlOut = '{cr1: crQ[0], cr2: crQ[1], cr3: crQ[2], cr4: crQ[3]};

	// status registers: a fault present in the clear cycle survives
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++)
				srQ[i] <= 24'h000000;
		end else if (clkEn) begin
			for (int i = 0; i < 3; i++) begin
				if (clrAll || (clrOne && endSrIdx == 2'(i)))
					srQ[i] <= srSet[i];
				else
					srQ[i] <= srQ[i] | srSet[i];
			end
		end
	end

endmodule // spi_frame_status_interface
`default_nettype wire

// *** spi_frame_status_properties.sv ***
// port-level checks of the serial frame interface
`timescale 1ns/10ps
`default_nettype none
`include "spi_frame_status_map.svh"
module spi_frame_status_properties (
	// clock, reset, enable
	input wire logic                            core_clk,
	input wire logic                            rst_n,
	input wire logic                            clkEn,
	// serial link pins
	input wire logic                            sclk,
	input wire logic                            csN,
	input wire logic                            sdi,
	input wire logic                            sdo,
	input wire logic                            sdoOe,
	// core side
	input wire spi_frame_status_pkg::fault_type faultIn,
	input wire logic                            limpHome,
	input wire spi_frame_status_pkg::ctrl_type  ctrlOut,
	input wire logic                            serialErr
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_reset_defaults: assert property ($rose(rst_n) |->
		ctrlOut == {`CR1_RST, `CR2_RST, `CR3_RST, `CR4_RST} && !serialErr)
		else $error("control defaults missing after reset");
	a_oe_starts: assert property ($fell(csN) |-> ##[1:5] sdoOe)
		else $error("output not enabled at frame start");
	a_oe_holds: assert property ((!csN)[*6] |-> sdoOe)
		else $error("output enable dropped inside frame");
	a_oe_idle: assert property (csN[*5] |-> !sdoOe)
		else $error("output enabled outside frame");
	a_ctrl_frozen: assert property ((!csN)[*6] |-> $stable(ctrlOut))
		else $error("control changed inside frame");
	a_err_after_frame: assert property ($changed(serialErr) |-> $past(csN, 3))
		else $error("serial error moved inside frame");
	a_sdo_steady: assert property ((sdoOe && $past(sdoOe) && $changed(sdo)) |->
		(!$past(sclk, 2) || !$past(sclk, 3) || !$past(sclk, 4)))
		else $error("output bit moved while serial clock high");
	a_nostat_limp: assert property (($fell(csN) && limpHome) |-> ##5 !sdo)
		else $error("no-status bit high while limp-home active");
endmodule // spi_frame_status_properties
`default_nettype wire

// *** spi_host_model.sv ***
// host master model driving the serial link in mode 0
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	// clock
	input  wire logic core_clk,
	// serial link pins
	output var  logic sclk,
	output var  logic csN,
	output var  logic sdi,
	input  wire logic sdo
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
	end

	// nClk other than 32 is only used for refused frames
	task automatic xfer(input logic [31:0] tx, input int nClk, output logic [31:0] rx);
		rx = '0;
		@(posedge core_clk) csN <= 1'b0;
		for (int i = 0; i < nClk; i++) begin
			sdi <= tx[31 - (i % 32)];
			repeat (4) @(posedge core_clk);
			sclk <= 1'b1;
			repeat (2) @(posedge core_clk);
			@(negedge core_clk) rx = {rx[30:0], sdo};
			repeat (2) @(posedge core_clk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		csN <= 1'b1;
		// released line shows the inverse, not a stale copy
		sdi <= ~sdi;
		repeat (8) @(posedge core_clk);
	endtask
endmodule // spi_host_model
`default_nettype wire

// *** test_spi_frame_status_interface.sv ***
// self-checking bench of the serial frame interface
`timescale 1ns/10ps
`default_nettype none
`include "spi_frame_status_map.svh"
module test_spi_frame_status_interface;
	import spi_frame_status_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sclk, csN, sdi, sdo, sdoOe, limpHome, serialErr;
	fault_type   faultIn;
	ctrl_type    ctrlOut;
	logic [31:0] rx;
	logic [5:0]  sa;
	int          sb;
	int          n_fail = 0;
	int          n_checks = 0;
	logic [31:0] badTx [5] = '{32'h00000000, 32'hFFFFFFFF, 32'h02000001, 32'h02000000, 32'h02000000};
	int          badCnt [5] = '{32, 32, 32, 31, 33};

	always #25 core_clk = ~core_clk;

	spi_frame_status_interface dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1),
		.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .faultIn(faultIn),
		.limpHome(limpHome), .ctrlOut(ctrlOut), .serialErr(serialErr));
	spi_host_model host_u (.core_clk(core_clk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

	task automatic chk_status(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t status byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_data(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic frame(input logic [1:0] op, input logic [5:0] addr, input logic [23:0] data);
		logic [31:0] tx;
		tx = {op, addr, data[23:1], 1'b0};
		tx[0] = ~^tx;
		host_u.xfer(tx, 32, rx);
	endtask
	// flags = {reset, serial error, limp}
	function automatic logic [7:0] exp_status(input logic [22:0] f, input logic [2:0] fl);
		logic [6:0] b;
		b = {fl[2:1], |({9'h160, 9'h160, 5'h00} & f), |({9'h09C, 9'h09C, 5'h18} & f),
			|(23'h000007 & f), |({9'h003, 9'h003, 5'h00} & f), fl[0]};
		return {~|b, b};
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		faultIn = '0;
		limpHome = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk_data(ctrlOut.cr1, `CR1_RST);
		frame(2'h0, 6'h02, 24'hFFFFF0);
		chk_status(rx[31:24], 8'h40);
		chk_data(ctrlOut.cr2, `CR2_RST);
		frame(2'h1, 6'h01, 24'h000000);
		chk_status(rx[31:24], 8'h80);
		chk_data(rx[23:0], `CR1_RST);
		for (int k = 0; k < 5; k++) begin
			host_u.xfer(badTx[k], badCnt[k], rx);
			chk_data({23'h0, serialErr}, 24'h000001);
			frame(2'h1, 6'h02, 24'h000000);
			chk_status(rx[31:24], 8'h20);
			chk_data(rx[23:0], `CR2_RST);
			chk_data({23'h0, serialErr}, 24'h000000);
		end
		frame(2'h0, 6'h02, 24'hA5A5A0);
		chk_data(rx[23:0], `CR2_RST);
		frame(2'h0, 6'h02, 24'h5A5A50);
		chk_data({rx[23:1], 1'b0}, 24'hA5A5A0);
		chk_data({ctrlOut.cr2[23:1], 1'b0}, 24'h5A5A50);
		frame(2'h0, 6'h01, 24'h802002);
		chk_data({23'h0, ctrlOut.cr1[`UNLOCK_POS]}, 24'h000001);
		frame(2'h1, 6'h04, 24'h000000);
		chk_data({ctrlOut.cr1[23:1], 1'b0}, 24'h802000);
		frame(2'h3, 6'h10, 24'h000000);
		chk_data(rx[23:0], 24'h000031);
		frame(2'h3, 6'h01, 24'h000000);
		chk_data(rx[23:0], 24'h000000);
		limpHome <= 1'b1;
		frame(2'h1, 6'h04, 24'h000000);
		chk_status(rx[31:24], 8'h01);
		limpHome <= 1'b0;
		for (int i = 0; i < 23; i++) begin
			sa = (i > 13) ? 6'h05 : (i > 4) ? 6'h06 : 6'h07;
			sb = (i > 13) ? i - 14 : (i > 4) ? i - 5 : i;
			@(posedge core_clk) faultIn <= fault_type'(23'h000001 << i);
			repeat (4) @(posedge core_clk);
			faultIn <= '0;
			frame(2'h2, sa, 24'h000000);
			chk_status(rx[31:24], exp_status(23'h000001 << i, 3'h0));
			chk_data(rx[23:0], 24'h000001 << sb);
			frame(2'h1, sa, 24'h000000);
			chk_status(rx[31:24], 8'h80);
			chk_data(rx[23:0], 24'h000000);
		end
		@(posedge core_clk) faultIn <= '1;
		repeat (4) @(posedge core_clk);
		faultIn <= '0;
		frame(2'h2, 6'h3F, 24'h000000);
		chk_status(rx[31:24], exp_status('1, 3'h0));
		frame(2'h1, 6'h06, 24'h000000);
		chk_status(rx[31:24], 8'h80);
		chk_data(rx[23:0], 24'h000000);
		wrap_up();
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		n_fail++;
		$display("ERROR %0t run did not finish", $time);
		wrap_up();
	end
endmodule // test_spi_frame_status_interface

bind spi_frame_status_interface spi_frame_status_properties chk_u (.core_clk(core_clk),
	.rst_n(rst_n), .clkEn(clkEn), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
	.sdoOe(sdoOe), .faultIn(faultIn), .limpHome(limpHome), .ctrlOut(ctrlOut),
	.serialErr(serialErr));
`default_nettype wire
